//--- dv/flag_state_gating_monitor.sv
`timescale 1ns/1ps
module flag_state_gating_monitor
  import flag_gate_pkg::*;
(
  // clock and reset
  input wire logic                 clock_in,
  input wire logic                 rst_in,
  // watched ports
  input wire module_state_t        module_state_in,
  input wire logic                 rd_en_in,
  input wire logic [7:0]           rd_addr_in,
  input wire logic                 mask_wr_en_in,
  input wire logic [NUM_LANES-1:0] rx_output_state_in,
  input wire logic [7:0]           rd_data_out,
  input wire logic                 rd_valid_out,
  input wire logic [NUM_LANES-1:0] rx_output_state_out,
  input wire logic                 host_int_out
);
  wire logic mapped = (rd_addr_in >= 8'h08 && rd_addr_in <= 8'h0B) ||
                      (rd_addr_in >= 8'h86 && rd_addr_in <= 8'h99);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  a_read_answered: assert property (rd_en_in |=> rd_valid_out)
    else $error("read not answered");
  a_valid_from_read: assert property (rd_valid_out |-> $past(rd_en_in))
    else $error("valid without read");
  a_data_holds: assert property (!rd_valid_out |-> $stable(rd_data_out))
    else $error("read data moved");
  a_unmapped_zero: assert property (rd_en_in && !mapped |=> rd_data_out == READ_MISS)
    else $error("unmapped read not zero");
  a_rx_state_copy: assert property (!$past(rst_in) |-> rx_output_state_out == $past(rx_output_state_in))
    else $error("rx status not copied");
  // blocked states cannot create new unmasked flags
  a_blocked_no_int: assert property (
    (module_state_in inside {MOD_RESET, MOD_MGMT_INIT} && !mask_wr_en_in) [*2] ##0 !host_int_out
    |=> !host_int_out)
    else $error("interrupt raised in blocked state");
  a_int_holds: assert property (host_int_out && !$past(rd_en_in) && !$past(mask_wr_en_in) |=> host_int_out)
    else $error("interrupt dropped without clear");
  a_reset_clean: assert property ($fell(rst_in) |-> !host_int_out && !rd_valid_out && rd_data_out == 8'h00)
    else $error("outputs not cleared by reset");
endmodule : flag_state_gating_monitor
bind flag_state_gating flag_state_gating_monitor mon (.clock_in(clock_in), .rst_in(rst_in),
  .module_state_in(module_state_in), .rd_en_in(rd_en_in), .rd_addr_in(rd_addr_in),
  .mask_wr_en_in(mask_wr_en_in), .rx_output_state_in(rx_output_state_in),
  .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
  .rx_output_state_out(rx_output_state_out), .host_int_out(host_int_out));

//--- dv/flag_state_gating_tb.sv
`timescale 1ns/1ps
module flag_state_gating_tb
  import flag_gate_pkg::*;
;
  logic clock_in, rst_in, vend, ok, rd_en, rd_mask, wr_en, rd_valid, hint, ei;
  logic [1:0] cfg;
  logic [7:0] quiet, rxs, rx_old, rd_addr, wr_addr, wr_data, rd_data, rxo, d;
  logic [7:0] msk [NUM_REGS];
  logic [7:0] e [NUM_REGS];
  logic [31:0] mev, lf;
  logic [NUM_EXT_GROUPS-1:0][7:0] lev;
  module_state_t mst;
  path_state_t pst [NUM_LANES];
  int err_total, checks_done;

  flag_state_gating uut (.clock_in(clock_in), .rst_in(rst_in), .module_state_in(mst),
    .lane_state_in(pst), .lane_tx_quiet_in(quiet), .aux_low_power_cfg_in(cfg),
    .vendor_low_power_in(vend), .module_event_in(mev), .lane_event_in(lev),
    .rx_output_state_in(rxs), .rd_en_in(rd_en), .rd_mask_in(rd_mask), .rd_addr_in(rd_addr),
    .mask_wr_en_in(wr_en), .mask_addr_in(wr_addr), .mask_data_in(wr_data),
    .rd_data_out(rd_data), .rd_valid_out(rd_valid), .rx_output_state_out(rxo),
    .host_int_out(hint));
  host_mgmt_model host (.clock_in(clock_in), .rd_en_out(rd_en), .rd_mask_out(rd_mask),
    .rd_addr_out(rd_addr), .mask_wr_en_out(wr_en), .mask_addr_out(wr_addr),
    .mask_data_out(wr_data), .rd_data_in(rd_data), .rd_valid_in(rd_valid));

  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt

  // allowed path states per lane group, bit n = path state code n
  function automatic logic [6:0] allow(input int g);
    case (g)
      0: return 7'h49;
      4: return 7'h7A;
      1, 5, 7, 9, 11, 13, 15, 17: return 7'h7F;
      default: return 7'h78;
    endcase
  endfunction : allow

  function automatic logic [7:0] perm(input int r);
    logic [7:0] b;
    logic [6:0] a;
    logic lp;
    a = allow(r - NUM_MOD_REGS);
    lp = mst inside {MOD_LOW_POWER, MOD_FAILED};
    b = 8'hFF;
    if (r < NUM_MOD_REGS) begin
      if (mst inside {MOD_RESETTING, MOD_RESET, MOD_MGMT_INIT}) b = 8'h00;
      else if (lp && r == 2) b = {{4{cfg[0]}}, 4'h0};
      else if (lp && r == 3) b = {{4{vend}}, {4{cfg[1]}}};
    end else if (mst inside {MOD_RESET, MOD_MGMT_INIT}) b = 8'h00;
    else foreach (pst[l]) b[l] = a[pst[l]] &&
      !(r > 8 && r < 17 && pst[l] == PATH_INITIALISED && quiet[l]);
    return b;
  endfunction : perm

  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] x);
    checks_done++;
    if (seen !== x) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, x, seen);
    end
  endtask : chk

  task automatic test_done();
    if (err_total == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done

  task automatic get(input logic [7:0] a, input logic m, input logic [7:0] x, input string n);
    host.rd(a, m, d, ok);
    if (!ok) begin
      err_total++;
      test_done();
    end
    chk(n, d, x);
  endtask : get

  initial begin
    {vend, cfg, quiet, rxs, mev, lev} = '0;
    rst_in = 1'b1;
    mst = MOD_RESETTING;
    foreach (pst[l]) pst[l] = PATH_IDLE;
    err_total = 0;
    checks_done = 0;
    lf = 32'h0000004C;
    repeat (6) @(negedge clock_in);
    rst_in = 1'b0;
    for (int r = 0; r < NUM_REGS; r++) begin
      get(REG_OFFSET[r], 1'b0, FLAG_RESET, "flag reset");
      get(REG_OFFSET[r], 1'b1, MASK_RESET, "mask reset");
    end
    // first eight passes walk every module state with all module and external lane events raised
    for (int it = 0; it < 40; it++) begin
      lf = nxt(lf);
      mst = (it < 8) ? module_state_t'(it[2:0]) : module_state_t'(lf[2:0]);
      foreach (pst[l]) pst[l] = path_state_t'(3'((l + it + lf[7:3]) % 7));
      {vend, cfg, quiet} = lf[18:8];
      for (int r = 0; r < NUM_REGS; r++) begin
        lf = nxt(lf);
        msk[r] = (it < 8) ? 8'h00 : lf[7:0];
        host.wr(REG_OFFSET[r], msk[r]);
      end
      lf = nxt(lf);
      mev = (it < 8) ? '1 : lf;
      for (int g = 0; g < NUM_EXT_GROUPS; g++) begin
        lf = nxt(lf);
        lev[g] = (it < 8) ? 8'hFF : lf[7:0];
      end
      rx_old = rxs;
      rxs = lf[15:8];
      ei = 1'b0;
      for (int r = 0; r < NUM_REGS; r++) begin
        e[r] = perm(r) & (r < 4 ? mev[8*r+:8] : r < NUM_REGS - 1 ? lev[r-4] : rx_old ^ rxs);
        ei |= |(e[r] & ~msk[r]);
      end
      @(negedge clock_in);
      mev = '0;
      lev = '0;
      mst = MOD_RESET;
      chk("rx status", rxo, rxs);
      @(negedge clock_in);
      chk("interrupt", {7'h00, hint}, {7'h00, ei});
      for (int r = 0; r < NUM_REGS; r++) get(REG_OFFSET[r], 1'b0, e[r], "flag byte");
      get(REG_OFFSET[it % NUM_REGS], 1'b1, msk[it % NUM_REGS], "mask byte");
      get({4'hA, lf[3:0]}, 1'b0, READ_MISS, "unmapped");
      repeat (2) @(negedge clock_in);
      chk("interrupt clear", {7'h00, hint}, 8'h00);
    end
    test_done();
  end
endmodule : flag_state_gating_tb

//--- dv/host_mgmt_model.sv
`timescale 1ns/1ps
module host_mgmt_model (
  // clock
  input  wire logic       clock_in,
  // requests
  output logic            rd_en_out,
  output logic            rd_mask_out,
  output logic      [7:0] rd_addr_out,
  output logic            mask_wr_en_out,
  output logic      [7:0] mask_addr_out,
  output logic      [7:0] mask_data_out,
  // answer
  input  wire logic [7:0] rd_data_in,
  input  wire logic       rd_valid_in
);
  initial begin
    {rd_en_out, rd_mask_out, rd_addr_out, mask_wr_en_out, mask_addr_out, mask_data_out} = '0;
  end
  // released address and data lines show inverted values so stale data cannot pass
  task automatic rd(input logic [7:0] a, input logic m, output logic [7:0] d, output logic ok);
    @(negedge clock_in);
    rd_en_out = 1'b1;
    rd_mask_out = m;
    rd_addr_out = a;
    @(negedge clock_in);
    rd_en_out = 1'b0;
    rd_addr_out = ~a;
    ok = 1'b0;
    d = 8'h00;
    for (int n = 0; n < 4 && !ok; n++) begin
      if (rd_valid_in) begin
        ok = 1'b1;
        d = rd_data_in;
      end else @(negedge clock_in);
    end
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clock_in);
    mask_wr_en_out = 1'b1;
    mask_addr_out = a;
    mask_data_out = v;
    @(negedge clock_in);
    mask_wr_en_out = 1'b0;
    mask_addr_out = ~a;
    mask_data_out = ~v;
  endtask : wr
endmodule : host_mgmt_model

//--- rtl/flag_byte_latch.sv
`timescale 1ns/1ps
module flag_byte_latch
  import flag_gate_pkg::*;
(
  // clock and reset
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  // set and clear
  input  wire logic [7:0] set_in,
  input  wire logic [7:0] clear_in,
  // latched flags
  output logic      [7:0] flags_out
);

  logic [7:0] flags_r;
  logic [7:0] flags_nxt;

  // set after clear, so a same-cycle event survives the read
  assign flags_nxt = (flags_r & ~clear_in) | set_in;  // RULE14
  assign flags_out = flags_r;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      flags_r <= FLAG_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

endmodule : flag_byte_latch

//--- rtl/flag_gate_pkg.sv
package flag_gate_pkg;

  // module state encoding, gray along resetting-reset-init-powerup-ready
  typedef enum logic [2:0] {
    MOD_RESETTING     = 3'h0,
    MOD_RESET         = 3'h1,
    MOD_MGMT_INIT     = 3'h3,
    MOD_PWR_UP        = 3'h2,
    MOD_OPERATIONAL   = 3'h6,
    MOD_PWR_DN        = 3'h7,
    MOD_LOW_POWER     = 3'h5,
    MOD_FAILED        = 3'h4
  } module_state_t;

  // path state encoding; the value also indexes the permission masks
  typedef enum logic [2:0] {
    PATH_IDLE         = 3'h0,
    PATH_INITIALISING = 3'h1,
    PATH_TEARDOWN     = 3'h2,
    PATH_INITIALISED  = 3'h3,
    PATH_TX_ENABLING  = 3'h4,
    PATH_TX_DISABLING = 3'h5,
    PATH_RUNNING      = 3'h6
  } path_state_t;

  localparam int NUM_LANES       = 8;
  localparam int NUM_MOD_REGS    = 4;
  localparam int NUM_LANE_GROUPS = 20;
  localparam int NUM_REGS        = NUM_MOD_REGS + NUM_LANE_GROUPS;
  localparam int NUM_PATH_STATES = 7;

  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] READ_MISS  = 8'h00;

  // register offsets, index order: four module bytes, then twenty lane groups
  localparam logic [7:0] REG_OFFSET [NUM_REGS] = '{
    8'h08, 8'h09, 8'h0A, 8'h0B,
    8'h86, 8'h87, 8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E, 8'h8F,
    8'h90, 8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97, 8'h98, 8'h99
  };

  // module-level layout: byte 10 = aux1 low / aux2 high, byte 11 = aux3 low / vendor high
  localparam int REG_MOD_EVENT = 0;
  localparam int REG_MOD_TEMP  = 1;
  localparam int REG_MOD_AUX_A = 2;
  localparam int REG_MOD_AUX_B = 3;
  localparam int NIB_LO        = 0;
  localparam int NIB_HI        = 4;
  localparam int NIB_W         = 4;

  // lane groups
  localparam int GRP_PATH_CHANGE = 0;
  localparam int GRP_TX_PWR_HA   = 5;
  localparam int GRP_TX_BIAS_LW  = 12;
  localparam int GRP_RX_OUT_CHG  = 19;
  localparam int NUM_EXT_GROUPS  = 19;

  // permission per lane group, bit n set = allowed in path state n
  localparam logic [6:0] ALLOW_ALL  = 7'h7F;
  localparam logic [6:0] ALLOW_LATE = 7'h78;
  localparam logic [6:0] ALLOW_CHG  = 7'h49;
  localparam logic [6:0] ALLOW_EQ   = 7'h7A;
  localparam logic [6:0] LANE_ALLOW [NUM_LANE_GROUPS] = '{
    ALLOW_CHG,  ALLOW_ALL,  ALLOW_LATE, ALLOW_LATE, ALLOW_EQ,
    ALLOW_ALL,  ALLOW_LATE, ALLOW_ALL,  ALLOW_LATE, ALLOW_ALL,
    ALLOW_LATE, ALLOW_ALL,  ALLOW_LATE,
    ALLOW_ALL,  ALLOW_LATE, ALLOW_ALL,  ALLOW_LATE, ALLOW_ALL,
    ALLOW_LATE, ALLOW_LATE
  };

endpackage : flag_gate_pkg

//--- rtl/flag_state_gating.sv
// What this block does
// (RULE1) module flag never set in module states marking it not allowed
// (RULE2) all module flags blocked in resetting, reset and management init
// (RULE3) module flag permission uses module state and configuration only
// (RULE4) lane flag never set in lane path states marking it not allowed
// (RULE5) all lane flags blocked in reset and management init module states
// (RULE6) otherwise each lane's path state selects its lane flag permission
// (RULE7) module monitor flags are only guaranteed in the operational state
// (RULE8) path monitor flags are only guaranteed in initialised and running states
// (RULE9) vendor monitor flag in low power or failed only if low-power capable
// (RULE10) tx power and bias flags blocked when initialised and tx is quieted
// (RULE11) rx output state fields stay valid in every path state
// (RULE12) no tx output change flag exists; only rx has one
// (RULE13) host may mask any flag any time after management is up
// (RULE14) gating only blocks setting; latched flags hold until read-cleared
// (RULE15) interrupt high while any unmasked flag is latched
// (RULE16) permissions are a constant lookup by flag group and state
`timescale 1ns/1ps
module flag_state_gating
  import flag_gate_pkg::*;
(
  // clock and reset
  input  wire logic                                   clock_in,
  input  wire logic                                   rst_in,
  // state machine states
  input  wire module_state_t                          module_state_in,
  input  wire path_state_t                            lane_state_in [NUM_LANES],
  // configuration
  input  wire logic [NUM_LANES-1:0]                   lane_tx_quiet_in,
  input  wire logic [1:0]                             aux_low_power_cfg_in,
  input  wire logic                                   vendor_low_power_in,
  // raw events
  input  wire logic [NUM_MOD_REGS*8-1:0]              module_event_in,
  input  wire logic [NUM_EXT_GROUPS-1:0][NUM_LANES-1:0] lane_event_in,
  input  wire logic [NUM_LANES-1:0]                   rx_output_state_in,
  // management register port
  input  wire logic                                   rd_en_in,
  input  wire logic                                   rd_mask_in,
  input  wire logic [7:0]                             rd_addr_in,
  input  wire logic                                   mask_wr_en_in,
  input  wire logic [7:0]                             mask_addr_in,
  input  wire logic [7:0]                             mask_data_in,
  output logic      [7:0]                             rd_data_out,
  output logic                                        rd_valid_out,
  // status and interrupt
  output logic      [NUM_LANES-1:0]                   rx_output_state_out,
  output logic                                        host_int_out
);

  // {hit, index} for a register offset
  function automatic logic [5:0] decode_addr(input logic [7:0] addr);
    logic [5:0] res;
    res = 6'h00;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (addr == REG_OFFSET[i]) begin
        res = {1'b1, 5'(i)};
      end
    end
    return res;
  endfunction : decode_addr

  // module-level permission: state and configuration, no path state
  function automatic logic [NUM_MOD_REGS*8-1:0] module_allow(
    input module_state_t st,
    input logic [1:0]    aux_lp,
    input logic          vend_lp
  );
    logic [NUM_MOD_REGS*8-1:0] a;
    a = '1;
    case (st)
      MOD_RESETTING, MOD_RESET, MOD_MGMT_INIT: begin
        a = '0;  // RULE2
      end
      MOD_LOW_POWER, MOD_FAILED: begin
        a[REG_MOD_AUX_A*8+NIB_LO +: NIB_W] = '0;  // RULE1
        a[REG_MOD_AUX_A*8+NIB_HI +: NIB_W] = {NIB_W{aux_lp[0]}};
        a[REG_MOD_AUX_B*8+NIB_LO +: NIB_W] = {NIB_W{aux_lp[1]}};
        a[REG_MOD_AUX_B*8+NIB_HI +: NIB_W] = {NIB_W{vend_lp}};  // RULE9
      end
      default: begin
        a = '1;  // RULE7
      end
    endcase
    return a;  // RULE3
  endfunction : module_allow

  // lane permission from module state, path state and tx quiet
  function automatic logic lane_allow(
    input int            grp,
    input module_state_t mst,
    input path_state_t   pst,
    input logic          quiet
  );
    logic ok;
    ok = 1'b0;
    if (mst != MOD_RESET && mst != MOD_MGMT_INIT) begin  // RULE5
      if (int'(pst) < NUM_PATH_STATES) begin
        ok = LANE_ALLOW[grp][pst];  // RULE6 RULE16 RULE8
      end
      if (quiet && pst == PATH_INITIALISED &&
          grp >= GRP_TX_PWR_HA && grp <= GRP_TX_BIAS_LW) begin
        ok = 1'b0;  // RULE10
      end
    end
    return ok;  // RULE4
  endfunction : lane_allow

  logic [NUM_MOD_REGS*8-1:0] mod_ok;
  logic [7:0]                set_vec [NUM_REGS];
  logic [7:0]                clr_vec [NUM_REGS];
  logic [7:0]                flag_q  [NUM_REGS];
  logic [7:0]                mask_r  [NUM_REGS];
  logic [NUM_REGS-1:0]       pend;
  logic [NUM_LANES-1:0]      rx_state_r;
  logic                      rx_primed_r;
  logic [NUM_LANES-1:0]      rx_change;
  logic [7:0]                rd_data_r;
  logic                      rd_valid_r;
  logic                      host_int_r;
  logic [5:0]                rd_dec;
  logic [5:0]                wr_dec;
  logic                      rd_flags;
  logic [7:0]                rd_data_nxt;

  assign mod_ok    = module_allow(module_state_in, aux_low_power_cfg_in, vendor_low_power_in);
  // no change flag until the first real sample, so reset cannot fake an edge
  assign rx_change = rx_primed_r ? (rx_state_r ^ rx_output_state_in) : '0;
  assign rd_dec    = decode_addr(rd_addr_in);
  assign wr_dec    = decode_addr(mask_addr_in);
  assign rd_flags  = rd_en_in & ~rd_mask_in & rd_dec[5];

  // module-level byte gating
  for (genvar r = 0; r < NUM_MOD_REGS; r++) begin : g_mod
    assign set_vec[r] = module_event_in[r*8 +: 8] & mod_ok[r*8 +: 8];  // RULE1
  end

  // lane byte gating; the rx output change group is fed internally
  for (genvar g = 0; g < NUM_LANE_GROUPS; g++) begin : g_grp
    for (genvar l = 0; l < NUM_LANES; l++) begin : g_lane
      logic evt;
      if (g == GRP_RX_OUT_CHG) begin : g_rx
        assign evt = rx_change[l];
      end else begin : g_ext
        assign evt = lane_event_in[g][l];
      end
      assign set_vec[NUM_MOD_REGS+g][l] = evt &
        lane_allow(g, module_state_in, lane_state_in[l], lane_tx_quiet_in[l]);  // RULE4
    end
  end

  // latches, read-clear and pending terms
  for (genvar r = 0; r < NUM_REGS; r++) begin : g_reg
    assign clr_vec[r] = (rd_flags && rd_dec[4:0] == 5'(r)) ? flag_q[r] : 8'h00;  // RULE14
    assign pend[r]    = |(flag_q[r] & ~mask_r[r]);  // RULE15
    flag_byte_latch u_latch (
      .clock_in  (clock_in),
      .rst_in    (rst_in),
      .set_in    (set_vec[r]),
      .clear_in  (clr_vec[r]),
      .flags_out (flag_q[r])
    );
  end

  assign rd_data_nxt = !rd_dec[5] ? READ_MISS :
                       rd_mask_in ? mask_r[rd_dec[4:0]] : flag_q[rd_dec[4:0]];

  // mask bits, written by the host at any time
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        mask_r[i] <= MASK_RESET;
      end
    end else if (mask_wr_en_in && wr_dec[5]) begin
      mask_r[wr_dec[4:0]] <= mask_data_in;  // RULE13
    end
  end

  // rx output state always tracked, independent of flag gating
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rx_state_r <= '0;
    end else begin
      rx_state_r <= rx_output_state_in;  // RULE11
    end
  end

  // marks that rx_state_r holds a real sample of the pins
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rx_primed_r <= 1'b0;
    end else begin
      rx_primed_r <= 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rd_data_r  <= READ_MISS;
      rd_valid_r <= 1'b0;
      host_int_r <= 1'b0;
    end else begin
      rd_data_r  <= rd_en_in ? rd_data_nxt : rd_data_r;
      rd_valid_r <= rd_en_in;
      host_int_r <= |pend;  // RULE15
    end
  end

  // only an rx output change group exists; tx has none
  assign rx_output_state_out = rx_state_r;  // RULE12
  assign rd_data_out         = rd_data_r;
  assign rd_valid_out        = rd_valid_r;
  assign host_int_out        = host_int_r;

endmodule : flag_state_gating
